// ### design/pwm_guard.sv
// pwm auto-shutdown, auto-restart, dead band and output steering
// assumes an upstream pwm source giving pwm_in and a period_start pulse,
// all inputs synchronous to clk, and an avalon-mm master with waitrequest
//
// The register offsets and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module pwm_guard
  import pwm_guard_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic pwm_in,
  input wire logic period_start,
  input wire logic ext_int_pin_n,
  input wire logic [1:0] comparator_output,
  output pwm_guard_pkg::pin_bus_s pins,
  output logic shutdown_active
);

  // ************************************************************
  // declarations
  // ************************************************************
  logic [7:0] module_control_reg;
  logic [7:0] shutdown_control_reg;
  logic [7:0] deadband_control_reg;
  logic [7:0] steering_control_reg;
  logic [3:0] steering_enable_bits;
  logic shutdown_event_flag;
  logic running;
  logic wr_strobe;
  logic flag_write;
  logic condition;
  logic [1:0] output_config_field;
  logic [3:0] mode_select_field;
  logic [2:0] shutdown_source;
  logic [1:0] pair_ac_shutdown_state;
  logic [1:0] pair_bd_shutdown_state;
  logic auto_restart_enable;
  logic [6:0] deadband_count;
  logic steering_sync;
  logic pwm_mode;
  logic [1:0] db_raw;
  logic [1:0] db_out;
  logic [db_cnt_w-1:0] db_load;
  logic [3:0] polarity_inv;
  logic [3:0] next_level;
  logic [3:0] next_oe;
  logic [3:0] run_level;
  logic [3:0] run_oe;
  logic [31:0] next_readdata;

  // ************************************************************
  // decode helpers
  // ************************************************************
  // drive enable of a pin pair in shutdown
  function automatic logic pss_drive(input logic [1:0] pss);
    pss_drive = (pss == pss_low) || (pss == pss_high);
  endfunction

  // level of a pin pair in shutdown
  function automatic logic pss_level(input logic [1:0] pss);
    pss_level = (pss == pss_high);
  endfunction

  // register select for a given offset
  function automatic logic hit(input logic [7:0] addr,
                               input logic [7:0] off);
    hit = (addr == off);
  endfunction

  // ************************************************************
  // field views
  // ************************************************************
  assign output_config_field = module_control_reg[cfg_msb:cfg_lsb];
  assign mode_select_field = module_control_reg[mode_msb:0];
  assign shutdown_source = shutdown_control_reg[src_msb:src_lsb];
  assign pair_ac_shutdown_state =
    shutdown_control_reg[pss_ac_msb:pss_ac_lsb];
  assign pair_bd_shutdown_state = shutdown_control_reg[pss_bd_msb:0];
  assign auto_restart_enable = deadband_control_reg[restart_bit];
  assign deadband_count = deadband_control_reg[dbc_msb:0];
  assign steering_sync = steering_control_reg[sync_bit];
  assign pwm_mode = (mode_select_field[mode_msb:2] == pwm_mode_bits);

  // ************************************************************
  // avalon-mm slave handshake
  // ************************************************************
  assign wr_strobe = write && !waitrequest && byteenable[0];
  assign flag_write = wr_strobe && hit(address, shutdown_control_off);

  // one wait state, then the answer edge
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      waitrequest <= 1'b1;
    end else if ((read || write) && waitrequest) begin
      waitrequest <= 1'b0;
    end else begin
      waitrequest <= 1'b1;
    end
  end

  always_comb begin
    next_readdata = 32'h0000_0000;
    if (hit(address, module_control_off)) begin
      next_readdata[7:0] = module_control_reg;
    end else if (hit(address, shutdown_control_off)) begin
      next_readdata[7:0] = {shutdown_event_flag,
                            shutdown_control_reg[src_msb:0]};
    end else if (hit(address, deadband_control_off)) begin
      next_readdata[7:0] = deadband_control_reg;
    end else if (hit(address, steering_control_off)) begin
      next_readdata[7:0] = steering_control_reg;
    end else if (hit(address, status_off)) begin
      next_readdata[7:0] = {2'h0, condition, running,
                            steering_enable_bits};
    end else begin
      next_readdata = 32'h0000_0000;
    end
  end

  // read data settles with the low waitrequest
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      readdata <= 32'h0000_0000;
    end else if (read && waitrequest) begin
      readdata <= next_readdata;
    end
  end

  // ************************************************************
  // control registers
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      module_control_reg <= ctrl_reset;
      shutdown_control_reg <= ctrl_reset;
      deadband_control_reg <= ctrl_reset;
      steering_control_reg <= ctrl_reset;
    end else if (wr_strobe) begin
      if (hit(address, module_control_off)) begin
        module_control_reg <= writedata[7:0];
      end else if (hit(address, shutdown_control_off)) begin
        shutdown_control_reg <= {1'b0, writedata[src_msb:0]};
      end else if (hit(address, deadband_control_off)) begin
        deadband_control_reg <= writedata[7:0];
      end else if (hit(address, steering_control_off)) begin
        steering_control_reg <= {3'h0, writedata[sync_bit:0]};
      end
    end
  end

  // ************************************************************
  // shutdown source and event flag
  // ************************************************************
  always_comb begin
    condition = 1'b0;
    if (shutdown_source[0] && comparator_output[0]) begin
      condition = 1'b1;
    end
    if (shutdown_source[1] && comparator_output[1]) begin
      condition = 1'b1;
    end
    if (shutdown_source[2] && !ext_int_pin_n) begin
      condition = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      shutdown_event_flag <= 1'b0;
    end else if (condition) begin
      shutdown_event_flag <= 1'b1;
    end else if (auto_restart_enable) begin
      shutdown_event_flag <= 1'b0;
    end else if (flag_write) begin
      shutdown_event_flag <= writedata[flag_bit];
    end
  end

  // outputs rejoin the pwm only at a period start
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      running <= 1'b1;
    end else if (shutdown_event_flag || condition ||
                 (flag_write && writedata[flag_bit])) begin
      running <= 1'b0;
    end else if (period_start) begin
      running <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      shutdown_active <= 1'b0;
    end else begin
      shutdown_active <= shutdown_event_flag || condition || !running;
    end
  end

  // ************************************************************
  // steering update
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      steering_enable_bits <= steer_reset;
    end else if (wr_strobe && hit(address, steering_control_off) &&
                 !writedata[sync_bit]) begin
      steering_enable_bits <= writedata[steer_msb:0];
    end else if (steering_sync && period_start) begin
      steering_enable_bits <= steering_control_reg[steer_msb:0];
    end
  end

  // ************************************************************
  // dead band, a from pwm and b from its complement
  // ************************************************************
  assign db_raw = {!pwm_in, pwm_in};
  assign db_load = db_cnt_w'(deadband_count) * db_cnt_w'(clk_per_tcy);

  generate
    for (genvar i = 0; i < 2; i++) begin : g_db
      logic [db_cnt_w-1:0] cnt;
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          cnt <= '0;
        end else if (!db_raw[i]) begin
          cnt <= db_load;
        end else if (cnt != '0) begin
          cnt <= cnt - 1'b1;
        end
      end
      // active only after the full delay, so a long delay hides it
      assign db_out[i] = db_raw[i] && (cnt == '0);
    end
  endgenerate

  // ************************************************************
  // running output mux
  // ************************************************************
  // bit1 inverts pair a/c, bit0 inverts pair b/d
  assign polarity_inv = {mode_select_field[0], mode_select_field[1],
                         mode_select_field[0], mode_select_field[1]};

  always_comb begin
    run_level = 4'h0;
    run_oe = 4'h0;
    if (pwm_mode && output_config_field == cfg_single) begin
      run_oe = steering_enable_bits;
      run_level = {4{pwm_in}} ^ polarity_inv;
    end else if (pwm_mode && output_config_field == cfg_half) begin
      run_oe = 4'h3;
      run_level = {2'h0, db_out} ^ {2'h0, polarity_inv[1:0]};
    end
  end

  // ************************************************************
  // shutdown override and pin registers
  // ************************************************************
  always_comb begin
    next_level = run_level;
    next_oe = run_oe;
    if (shutdown_event_flag || condition || !running) begin
      for (int p = 0; p < 4; p++) begin
        if (run_oe[p]) begin
          if (p[0] == 1'b0) begin
            next_oe[p] = pss_drive(pair_ac_shutdown_state);
            next_level[p] = pss_level(pair_ac_shutdown_state);
          end else begin
            next_oe[p] = pss_drive(pair_bd_shutdown_state);
            next_level[p] = pss_level(pair_bd_shutdown_state);
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pins <= '0;
    end else begin
      pins.level <= next_level;
      pins.oe <= next_oe;
    end
  end

endmodule // pwm_guard

`default_nettype wire

// ### common/pwm_guard_pkg.sv
// constants, types and register map of the pwm protection and steering block
// assumes a 100 MHz clock that also serves as the oscillator period
package pwm_guard_pkg;

  // register byte offsets
  localparam logic [7:0] module_control_off = 8'h00;
  localparam logic [7:0] shutdown_control_off = 8'h04;
  localparam logic [7:0] deadband_control_off = 8'h08;
  localparam logic [7:0] steering_control_off = 8'h0c;
  localparam logic [7:0] status_off = 8'h10;

  // field positions
  localparam int cfg_msb = 7;
  localparam int cfg_lsb = 6;
  localparam int mode_msb = 3;
  localparam int flag_bit = 7;
  localparam int src_msb = 6;
  localparam int src_lsb = 4;
  localparam int pss_ac_msb = 3;
  localparam int pss_ac_lsb = 2;
  localparam int pss_bd_msb = 1;
  localparam int restart_bit = 7;
  localparam int dbc_msb = 6;
  localparam int sync_bit = 4;
  localparam int steer_msb = 3;

  // reset values
  localparam logic [7:0] ctrl_reset = 8'h00;
  localparam logic [3:0] steer_reset = 4'h0;

  // encodings
  localparam logic [1:0] pwm_mode_bits = 2'h3;
  localparam logic [1:0] cfg_single = 2'h0;
  localparam logic [1:0] cfg_half = 2'h2;
  localparam logic [1:0] pss_low = 2'h0;
  localparam logic [1:0] pss_high = 2'h1;

  // timing: one instruction cycle is four oscillator periods
  localparam int tosc_ns = 10;
  localparam int tcy_in_tosc = 4;
  localparam int tcy_ns = tcy_in_tosc * tosc_ns;
  localparam int clk_per_tcy = tcy_ns / tosc_ns;
  localparam int db_cnt_w = 9;

  typedef struct packed {
    logic [3:0] level;
    logic [3:0] oe;
  } pin_bus_s;

endpackage

// ### bench/bridge_model.sv
// far-side model: comparators, shutdown pin and the pins' loads
// assumes the bench asks for trips synchronous to clk
`timescale 1ns/1ps
`default_nettype none
// ****
// shutdown sources and pin loads
// ****
module bridge_model (
  input wire logic [2:0] trip,
  input wire pwm_guard_pkg::pin_bus_s pins,
  output logic [1:0] comparator_output,
  output logic ext_int_pin_n,
  output logic [3:0] wire_level
);
  import pwm_guard_pkg::*;
  // comparators trip high, the pin trips low
  assign comparator_output = trip[1:0];
  assign ext_int_pin_n = ~trip[2];
  // released pins fall to the pull-down
  assign wire_level = pins.level & pins.oe;
endmodule // bridge_model
`default_nettype wire

// ### bench/pwm_guard_properties.sv
// port-level checker for pwm_guard
// assumes binding to pwm_guard, one clock domain
`timescale 1ns/1ps
`default_nettype none
// ****
// checker
// ****
module pwm_guard_properties (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic pwm_in,
  input wire logic period_start,
  input wire logic ext_int_pin_n,
  input wire logic [1:0] comparator_output,
  input wire pwm_guard_pkg::pin_bus_s pins,
  input wire logic shutdown_active
);
  import pwm_guard_pkg::*;
  logic [2:0] src;
  logic [1:0] ac;
  logic [7:0] mc;
  logic [6:0] dbc;
  logic [9:0] hc;
  logic wr;
  logic cond;
  logic half;
  assign wr = write && !waitrequest && byteenable[0];
  assign cond = |(src & {~ext_int_pin_n, comparator_output});
  assign half = mc[7:6] == cfg_half && mc[3:2] == pwm_mode_bits;
  // shadow of the written control fields
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      src <= 3'h0;
      ac <= 2'h0;
      mc <= 8'h00;
      dbc <= 7'h00;
    end else if (wr && address == shutdown_control_off) begin
      src <= writedata[6:4];
      ac <= writedata[3:2];
    end else if (wr && address == module_control_off) begin
      mc <= writedata[7:0];
    end else if (wr && address == deadband_control_off) begin
      dbc <= writedata[6:0];
    end
  end
  // length of the current high run of raw pwm
  always_ff @(posedge clk) begin
    hc <= !pwm_in ? 10'h000 : hc + {9'h000, ~&hc};
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  chk_cond_shuts_down: assert property (cond |=> shutdown_active)
    else $error("shutdown source did not shut down");
  chk_hiz_pair_ac: assert property ($past(cond) && $past(ac[1]) |->
    pins.oe[0] == 1'b0 && pins.oe[2] == 1'b0)
    else $error("pair a c not released in shutdown");
  chk_drive_pair_ac: assert property ($past(cond) && !$past(ac[1]) &&
    pins.oe[0] |-> pins.level[0] == $past(ac[0]))
    else $error("pin a not at shutdown level");
  chk_resume_at_period: assert property ($fell(shutdown_active) |->
    $past(period_start, 2))
    else $error("output resumed off a period start");
  chk_half_cd_free: assert property ($past(half) |-> pins.oe[3:2] == 2'h0)
    else $error("pins c d driven in half bridge");
  chk_deadband_min: assert property ($rose(pins.level[0]) &&
    $past(half) && $past(half, 2) && !mc[1] && !$past(shutdown_active) |->
    hc >= {1'b0, dbc, 2'h0})
    else $error("pin a rose before dead band ran out");
  chk_wait_one_cycle: assert property ($fell(waitrequest) |=> waitrequest)
    else $error("waitrequest low for more than one cycle");
  chk_read_answered: assert property ($rose(read) |=> !waitrequest)
    else $error("read not answered next cycle");
  chk_reset_quiet: assert property (disable iff (1'b0) !reset_n |=>
    pins.oe == 4'h0 && !shutdown_active && waitrequest)
    else $error("outputs not quiet in reset");
  cov_shutdown: cover property (cond ##1 shutdown_active);
  cov_resume: cover property ($fell(shutdown_active));
  cov_deadband: cover property ($rose(pins.level[0]) && half);
endmodule // pwm_guard_properties
bind pwm_guard pwm_guard_properties u_props (.clk(clk), .reset_n(reset_n),
  .address(address), .read(read), .write(write), .byteenable(byteenable),
  .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
  .pwm_in(pwm_in), .period_start(period_start), .pins(pins),
  .ext_int_pin_n(ext_int_pin_n), .comparator_output(comparator_output),
  .shutdown_active(shutdown_active));
`default_nettype wire

// ### bench/tb_top.sv
// self-checking bench for pwm_guard
// assumes bridge_model and the bound checker are compiled
`timescale 1ns/1ps
`default_nettype none
// ****
// bench
// ****
module tb_top;
  import pwm_guard_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [3:0] byteenable = 4'h1;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic [31:0] rd;
  logic waitrequest;
  logic pwm_in = 1'b0;
  logic period_start = 1'b0;
  logic ext_int_pin_n;
  logic shutdown_active;
  logic [1:0] comparator_output;
  logic [2:0] trip = 3'h0;
  logic [3:0] wire_level;
  logic [4:0] pc = 5'h00;
  logic [5:0] duty = 6'h00;
  logic [7:0] v;
  pin_bus_s pins;
  int err_count = 0;
  int checks = 0;
  int i;
  initial forever #5 clk = ~clk;
  // upstream period and duty source, period of 32 clocks
  always @(posedge clk) begin
    pc <= pc + 5'h01;
    period_start <= pc == 5'h1f;
    pwm_in <= {1'b0, pc} < duty;
  end
  pwm_guard u_dut (.clk(clk), .reset_n(reset_n), .address(address),
    .read(read), .write(write), .byteenable(byteenable),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .pwm_in(pwm_in), .period_start(period_start),
    .ext_int_pin_n(ext_int_pin_n), .comparator_output(comparator_output),
    .pins(pins), .shutdown_active(shutdown_active));
  bridge_model u_model (.trip(trip), .pins(pins),
    .comparator_output(comparator_output), .ext_int_pin_n(ext_int_pin_n),
    .wire_level(wire_level));
  task automatic chk(input string nm, input logic [31:0] s,
    input logic [31:0] e);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    address <= a;
    writedata <= {24'h0, d};
    write <= w;
    read <= !w;
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk("readdata", rd, {24'h0, e});
  endtask
  task automatic cnt(input int b, input int e);
    int n;
    n = 0;
    repeat (32) begin
      @(negedge clk);
      n += (wire_level[b] === 1'b1);
    end
    chk("pin high count", n, e);
  endtask
  task automatic ps;
    @(negedge clk);
    while (period_start !== 1'b1) @(negedge clk);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clk);
    err_count++;
    end_sim;
  end
  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    chk("pins oe", pins.oe, 4'h0);
    for (i = 0; i < 6; i++) if (i != 4) rchk(8'(i * 4), 8'h00);
    duty <= 6'd10;
    bus(1'b1, module_control_off, 8'h0c);
    ps;
    bus(1'b1, steering_control_off, 8'h05);
    rchk(status_off, 8'h15);
    repeat (64) @(posedge clk);
    cnt(0, 10);
    cnt(2, 10);
    for (i = 0; i < 3; i++) begin
      v = (8'h10 << i) | 8'h06;
      bus(1'b1, shutdown_control_off, v);
      trip <= 3'h1 << i;
      repeat (3) @(posedge clk);
      rchk(shutdown_control_off, v | 8'h80);
      chk("pin levels", wire_level, 4'h5);
      chk("pins oe", pins.oe, 4'h5);
      bus(1'b1, shutdown_control_off, v);
      rchk(shutdown_control_off, v | 8'h80);
      trip <= 3'h0;
      repeat (3) @(posedge clk);
      rchk(shutdown_control_off, v | 8'h80);
      bus(1'b1, shutdown_control_off, v);
      rchk(shutdown_control_off, v);
    end
    repeat (64) @(posedge clk);
    cnt(0, 10);
    bus(1'b1, deadband_control_off, 8'h80);
    bus(1'b1, shutdown_control_off, 8'h18);
    trip <= 3'h1;
    repeat (3) @(posedge clk);
    rchk(shutdown_control_off, 8'h98);
    chk("pins oe", pins.oe, 4'h0);
    trip <= 3'h0;
    repeat (3) @(posedge clk);
    rchk(shutdown_control_off, 8'h18);
    bus(1'b1, shutdown_control_off, 8'h90);
    rchk(shutdown_control_off, 8'h10);
    bus(1'b1, deadband_control_off, 8'h00);
    bus(1'b1, shutdown_control_off, 8'h90);
    rchk(shutdown_control_off, 8'h90);
    bus(1'b1, shutdown_control_off, 8'h10);
    ps;
    bus(1'b1, steering_control_off, 8'h13);
    rchk(status_off, 8'h15);
    ps;
    rchk(status_off, 8'h13);
    bus(1'b1, module_control_off, 8'h0d);
    repeat (64) @(posedge clk);
    cnt(0, 10);
    cnt(1, 22);
    bus(1'b1, module_control_off, 8'h0e);
    repeat (64) @(posedge clk);
    cnt(0, 22);
    duty <= 6'd16;
    bus(1'b1, deadband_control_off, 8'h05);
    bus(1'b1, module_control_off, 8'h8c);
    repeat (64) @(posedge clk);
    cnt(0, 0);
    cnt(1, 0);
    bus(1'b1, deadband_control_off, 8'h03);
    repeat (64) @(posedge clk);
    cnt(0, 4);
    cnt(1, 4);
    chk("pins oe", pins.oe, 4'h3);
    end_sim;
  end
endmodule // tb_top
`default_nettype wire
